/* core/rtss_defs.svh */
// register offsets, field positions, codes and reset values of the schedule block
// assumes a 32-bit apb slave with byte addresses in an 8-bit window
`ifndef RTSS_DEFS_SVH
`define RTSS_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RTSS_ADDR_MODE 8'h00
`define RTSS_ADDR_TSRC 8'h04
`define RTSS_ADDR_WIN0 8'h08
`define RTSS_ADDR_WIN3 8'h14
`define RTSS_ADDR_OFS 8'h18
`define RTSS_ADDR_RELAY 8'h1c
`define RTSS_ADDR_STAT 8'h20

// ----------------------------------------------------------------
// mode register fields (lsb positions)
// ----------------------------------------------------------------
`define RTSS_MODE_TFUN 0
`define RTSS_MODE_OSEL 2
`define RTSS_MODE_SPD 4
`define RTSS_MODE_DIR 8
`define RTSS_MODE_RUN 12
`define RTSS_MODE_FRQ 16
`define RTSS_MODE_LOCK 20

// ----------------------------------------------------------------
// window register fields (lsb positions)
// ----------------------------------------------------------------
`define RTSS_WIN_START 0
`define RTSS_WIN_STOP 11
`define RTSS_WIN_SDAY 22
`define RTSS_WIN_EDAY 25

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define RTSS_TFUN_ON 2'h1
`define RTSS_TFUN_DI 2'h2
`define RTSS_SPD_OFF 3'h0
`define RTSS_SPD_PAIR 3'h5
`define RTSS_RUN_SCHED 3'h4
`define RTSS_FRQ_SCHED 4'h6
`define RTSS_LOCK_NO_REV 2'h1
`define RTSS_LOCK_NO_FWD 2'h2
`define RTSS_REG_RESET 32'h0000_0000

`endif

/* core/rtss_pkg.sv */
// types shared by the schedule block and its window evaluator
// assumes minute-of-day counting from 0 to 1439
package rtss_pkg;
  typedef logic [10:0] rtss_minute_type;
  typedef logic [2:0] rtss_day_type;
  typedef logic [4:0] rtss_mask_type;
endpackage : rtss_pkg

/* core/rtss_win_if.sv */
// carrier between the schedule core and one time-window evaluator
// assumes the core drives settings and clock time, the evaluator answers
`timescale 1ns/1ps
`default_nettype none
interface rtss_win_if;
  rtss_pkg::rtss_minute_type start_min;
  rtss_pkg::rtss_minute_type stop_min;
  rtss_pkg::rtss_minute_type now_min;
  rtss_pkg::rtss_day_type start_day;
  rtss_pkg::rtss_day_type stop_day;
  rtss_pkg::rtss_day_type now_day;
  logic active;
  modport eval (input start_min, stop_min, now_min, start_day, stop_day, now_day,
    output active);
  modport cfg (output start_min, stop_min, now_min, start_day, stop_day, now_day,
    input active);
endinterface : rtss_win_if
`default_nettype wire

/* core/rtss_window.sv */
// one weekly time window: weekday range and inclusive minute range
// assumes weekday 1..7 and minutes of day below 1440
`timescale 1ns/1ps
`default_nettype none
module rtss_window (
  rtss_win_if.eval win
);
  logic day_ok;
  logic time_ok;

  // ----------------------------------------------------------------
  // window evaluation
  // ----------------------------------------------------------------
  // ranges may wrap past sunday or past midnight
  always_comb begin
    if (win.start_day <= win.stop_day) begin
      day_ok = (win.now_day >= win.start_day) && (win.now_day <= win.stop_day);
    end else begin
      day_ok = (win.now_day >= win.start_day) || (win.now_day <= win.stop_day);
    end
    // [RULE5] stop minute inclusive
    if (win.start_min < win.stop_min) begin
      time_ok = (win.now_min >= win.start_min) && (win.now_min <= win.stop_min);
    end else begin
      time_ok = (win.now_min >= win.start_min) || (win.now_min <= win.stop_min);
    end
  end

  // [RULE19] weekday and time match
  // [RULE17] equal start and stop disables
  assign win.active = day_ok && time_ok && (win.start_min != win.stop_min);
endmodule : rtss_window
`default_nettype wire

/* core/rtss_sched.sv */
// schedule core: timers from weekly windows, speed stage, direction, run gate
// assumes clock time and inputs synchronous to pclk; apb slave, zero wait
// Functional notes
// [RULE1] timer source is 5-bit mask: bits 0-3 windows, bit 4 offset, 0 none
// [RULE2] timer is OR of all selected windows
// [RULE3] mask bit 4 ORs the offset window into the timer
// [RULE4] one relay per timer; later duplicate relay mapping is ignored
// [RULE5] stop minute is inclusive, window ends the minute after
// [RULE6] speed selection 0 leaves frequency and direction untouched
// [RULE7] selections 1-4: that timer gates, speed stage zero
// [RULE8] selection 5: timers one and two form the stage code
// [RULE9] selection 5: same code picks the direction bit
// [RULE10] each timer evaluated on its own mask only
// [RULE11] scheduled frequency needs frequency source 6 and run source schedule
// [RULE12] fire mode input or kinetic ride-through forces schedule off
// [RULE13] run source 0-3 never grants a run from timers
// [RULE14] run source 4 runs only while relevant timer active
// [RULE15] direction lock blocks a locked-out scheduled direction
// [RULE16] direction field: one bit per case, 0 forward, 1 reverse
// [RULE17] window with equal start and stop never activates
// [RULE18] timer function 0 off, 1 on, 2 on while digital input asserted
// [RULE19] window active within weekday range and time range
// [RULE20] outputs registered, reset to inactive, stage zero, forward
`include "rtss_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rtss_sched (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] now_day,
  input wire logic [4:0] now_hour,
  input wire logic [5:0] now_minute,
  input wire logic timer_di,
  input wire logic offset_di,
  input wire logic fire_mode_cfg,
  input wire logic kinetic_ride_through_en,
  output logic [3:0] timer_state,
  output logic [1:0] speed_stage,
  output logic dir_reverse,
  output logic run_grant,
  output logic freq_from_sched,
  output logic dir_from_sched,
  output logic [3:0] relay_out
);
  logic [31:0] mode_q, mode_d, tsrc_q, tsrc_d, ofs_q, ofs_d, relay_q, relay_d;
  logic [31:0] win_q [4];
  logic [31:0] win_d [4];
  logic [31:0] prdata_q, prdata_d;
  logic [3:0] timer_q, timer_d, relay_out_q, relay_out_d, win_act;
  logic [1:0] stage_q, stage_d;
  logic dir_q, dir_d, grant_q, grant_d, freq_q, freq_d, dsel_q, dsel_d;
  logic wr_en, rd_en, acc, addr_ok, sched_en, ofs_act, gate, req_rev, dir_ok;
  logic [2:0] spd_sel, run_src;
  logic [1:0] tfun, osel, lock;
  logic [3:0] dir_bits, frq_src;
  logic [2:0] eff_map [4];
  logic [3:0] dup;
  rtss_pkg::rtss_minute_type now_min;
  rtss_win_if win_bus [4] ();

  // ----------------------------------------------------------------
  // apb access
  // ----------------------------------------------------------------
  // zero wait: every access phase completes at its first edge
  assign acc = psel && penable;
  assign wr_en = acc && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = acc && !addr_ok;
  assign prdata = prdata_q;

  // address decode
  always_comb begin
    if (paddr == `RTSS_ADDR_MODE) begin
      addr_ok = 1'b1;
    end else if (paddr == `RTSS_ADDR_TSRC) begin
      addr_ok = 1'b1;
    end else if ((paddr >= `RTSS_ADDR_WIN0) && (paddr <= `RTSS_ADDR_WIN3)
                 && (paddr[1:0] == 2'h0)) begin
      addr_ok = 1'b1;
    end else if (paddr == `RTSS_ADDR_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == `RTSS_ADDR_RELAY) begin
      addr_ok = 1'b1;
    end else if (paddr == `RTSS_ADDR_STAT) begin
      addr_ok = !pwrite;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // byte lanes merged so partial writes keep the other bytes
  function automatic logic [31:0] rtss_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : rtss_merge

  // register writes in the access phase, read data capture in the setup phase
  always_comb begin
    mode_d = mode_q;
    tsrc_d = tsrc_q;
    ofs_d = ofs_q;
    relay_d = relay_q;
    prdata_d = prdata_q;
    for (int w = 0; w < 4; w++) begin
      win_d[w] = win_q[w];
    end
    if (wr_en) begin
      if (paddr == `RTSS_ADDR_MODE) begin
        mode_d = rtss_merge(mode_q, pwdata, pstrb);
      end else if (paddr == `RTSS_ADDR_TSRC) begin
        tsrc_d = rtss_merge(tsrc_q, pwdata, pstrb);
      end else if (paddr == `RTSS_ADDR_OFS) begin
        ofs_d = rtss_merge(ofs_q, pwdata, pstrb);
      end else if (paddr == `RTSS_ADDR_RELAY) begin
        relay_d = rtss_merge(relay_q, pwdata, pstrb);
      end else begin
        win_d[paddr[3:2] - 2'h2] = rtss_merge(win_q[paddr[3:2] - 2'h2], pwdata, pstrb);
      end
    end
    if (rd_en) begin
      if (paddr == `RTSS_ADDR_MODE) begin
        prdata_d = mode_q;
      end else if (paddr == `RTSS_ADDR_TSRC) begin
        prdata_d = tsrc_q;
      end else if ((paddr >= `RTSS_ADDR_WIN0) && (paddr <= `RTSS_ADDR_WIN3)) begin
        prdata_d = win_q[paddr[3:2] - 2'h2];
      end else if (paddr == `RTSS_ADDR_OFS) begin
        prdata_d = ofs_q;
      end else if (paddr == `RTSS_ADDR_RELAY) begin
        prdata_d = relay_q;
      end else if (paddr == `RTSS_ADDR_STAT) begin
        prdata_d = {19'h0_0000, dup, sched_en, grant_q, dir_q, stage_q, timer_q};
      end else begin
        prdata_d = `RTSS_REG_RESET;
      end
    end
  end

  // ----------------------------------------------------------------
  // settings decode and time windows
  // ----------------------------------------------------------------
  assign tfun = mode_q[`RTSS_MODE_TFUN +: 2];
  assign osel = mode_q[`RTSS_MODE_OSEL +: 2];
  assign spd_sel = mode_q[`RTSS_MODE_SPD +: 3];
  assign dir_bits = mode_q[`RTSS_MODE_DIR +: 4];
  assign run_src = mode_q[`RTSS_MODE_RUN +: 3];
  assign frq_src = mode_q[`RTSS_MODE_FRQ +: 4];
  assign lock = mode_q[`RTSS_MODE_LOCK +: 2];
  assign now_min = ({6'h00, now_hour} << 6) - ({6'h00, now_hour} << 2) + {5'h00, now_minute};

  // [RULE18] timer function enable
  // [RULE12] fire mode or ride-through override
  assign sched_en = ((tfun == `RTSS_TFUN_ON) || ((tfun == `RTSS_TFUN_DI) && timer_di))
                    && !fire_mode_cfg && !kinetic_ride_through_en;

  // offset window from its preset minute to the end of the day
  assign ofs_act = ((osel == `RTSS_TFUN_ON) || ((osel == `RTSS_TFUN_DI) && offset_di))
                   && (now_min >= ofs_q[10:0]);

  // one evaluator per window
  for (genvar g = 0; g < 4; g++) begin : g_win
    assign win_bus[g].start_min = win_q[g][`RTSS_WIN_START +: 11];
    assign win_bus[g].stop_min = win_q[g][`RTSS_WIN_STOP +: 11];
    assign win_bus[g].start_day = win_q[g][`RTSS_WIN_SDAY +: 3];
    assign win_bus[g].stop_day = win_q[g][`RTSS_WIN_EDAY +: 3];
    assign win_bus[g].now_min = now_min;
    assign win_bus[g].now_day = now_day;
    assign win_act[g] = win_bus[g].active;
    rtss_window u_win (
      .win(win_bus[g])
    );
    // [RULE1] mask picks sources
    // [RULE2] [RULE3] [RULE10] own mask only
    assign timer_d[g] = sched_en && |(tsrc_q[g*8 +: 5] & {ofs_act, win_act});
  end

  // ----------------------------------------------------------------
  // speed stage, direction and run gate
  // ----------------------------------------------------------------
  // computed from registered timers, so they trail timer_state by one edge
  always_comb begin
    gate = 1'b0;
    stage_d = 2'h0;
    req_rev = dir_bits[0];
    // [RULE7] single timer, stage zero
    if ((spd_sel != `RTSS_SPD_OFF) && (spd_sel < `RTSS_SPD_PAIR)) begin
      gate = timer_q[spd_sel[1:0] - 2'h1];
    // [RULE8] [RULE9] timer pair code
    end else if (spd_sel == `RTSS_SPD_PAIR) begin
      gate = timer_q[0] || timer_q[1];
      stage_d = timer_q[1:0];
      // [RULE16] bit 0 forward, 1 reverse
      req_rev = dir_bits[timer_q[1:0]];
    end
    // [RULE15] locked direction refused
    dir_ok = !((lock == `RTSS_LOCK_NO_REV) && req_rev)
             && !((lock == `RTSS_LOCK_NO_FWD) && !req_rev);
    // [RULE6] selection 0 or invalid leaves the drive alone
    dsel_d = sched_en && gate && (spd_sel != `RTSS_SPD_OFF) && (spd_sel <= `RTSS_SPD_PAIR);
    // [RULE11] frequency needs both sources on the schedule
    freq_d = dsel_d && (frq_src == `RTSS_FRQ_SCHED) && (run_src == `RTSS_RUN_SCHED);
    // [RULE13] [RULE14] run only from run source 4
    grant_d = dsel_d && (run_src == `RTSS_RUN_SCHED) && dir_ok;
    dir_d = dsel_d && dir_ok && req_rev;
  end

  // [RULE4] later duplicate relay mapping ignored
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      eff_map[r] = (relay_q[r*4 +: 3] > 3'h4) ? 3'h0 : relay_q[r*4 +: 3];
      dup[r] = 1'b0;
      for (int k = 0; k < r; k++) begin
        if ((eff_map[r] != 3'h0) && (eff_map[k] == eff_map[r])) begin
          dup[r] = 1'b1;
        end
      end
      if (dup[r]) begin
        eff_map[r] = 3'h0;
      end
      relay_out_d[r] = (eff_map[r] != 3'h0) && timer_q[eff_map[r][1:0] - 2'h1];
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // [RULE20] reset to inactive, stage zero, forward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `RTSS_REG_RESET;
      tsrc_q <= `RTSS_REG_RESET;
      ofs_q <= `RTSS_REG_RESET;
      relay_q <= `RTSS_REG_RESET;
      prdata_q <= `RTSS_REG_RESET;
      for (int w = 0; w < 4; w++) begin
        win_q[w] <= `RTSS_REG_RESET;
      end
      timer_q <= 4'h0;
      stage_q <= 2'h0;
      dir_q <= 1'b0;
      grant_q <= 1'b0;
      freq_q <= 1'b0;
      dsel_q <= 1'b0;
      relay_out_q <= 4'h0;
    end else begin
      mode_q <= mode_d;
      tsrc_q <= tsrc_d;
      ofs_q <= ofs_d;
      relay_q <= relay_d;
      prdata_q <= prdata_d;
      for (int w = 0; w < 4; w++) begin
        win_q[w] <= win_d[w];
      end
      timer_q <= timer_d;
      stage_q <= stage_d;
      dir_q <= dir_d;
      grant_q <= grant_d;
      freq_q <= freq_d;
      dsel_q <= dsel_d;
      relay_out_q <= relay_out_d;
    end
  end

  assign timer_state = timer_q;
  assign speed_stage = stage_q;
  assign dir_reverse = dir_q;
  assign run_grant = grant_q;
  assign freq_from_sched = freq_q;
  assign dir_from_sched = dsel_q;
  assign relay_out = relay_out_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_MASK_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    timer_state[0] |-> $past(tsrc_q[4:0]) != 5'h00)
    else $error("timer 0 active with empty mask");
  AST_TIMER_OR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    (sched_en && |(tsrc_q[11:8] & win_act)) |=> timer_state[1])
    else $error("timer 1 missed a selected window");
  AST_OFFSET_OR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
    (sched_en && tsrc_q[4] && ofs_act) |=> timer_state[0])
    else $error("offset window not ORed into timer 0");
  AST_RELAY_ONE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    (eff_map[0] != 3'h0) |-> (eff_map[1] != eff_map[0]) && (eff_map[2] != eff_map[0])
    && (eff_map[3] != eff_map[0]))
    else $error("two relays mapped to one timer");
  AST_STOP_INCL: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    (win_bus[0].now_min == win_bus[0].stop_min) && (win_bus[0].start_min < win_bus[0].stop_min)
    && (now_day == win_bus[0].start_day) |-> win_act[0])
    else $error("window dropped during its stop minute");
  AST_SEL_OFF: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    (spd_sel == `RTSS_SPD_OFF) |=> !dir_from_sched && !freq_from_sched && !run_grant)
    else $error("schedule acted with speed selection 0");
  AST_SINGLE_STAGE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    (spd_sel != `RTSS_SPD_OFF) && (spd_sel < `RTSS_SPD_PAIR) |=> speed_stage == 2'h0)
    else $error("single timer selection left stage zero");
  AST_PAIR_STAGE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    (spd_sel == `RTSS_SPD_PAIR) |=> speed_stage == $past(timer_state[1:0]))
    else $error("pair stage does not follow timers one and two");
  AST_FIRE_OFF: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    (fire_mode_cfg || kinetic_ride_through_en) |=> !run_grant && timer_state == 4'h0)
    else $error("schedule still active under fire mode or ride-through");
  AST_RUN_SRC_LOW: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    (run_src < `RTSS_RUN_SCHED) |=> !run_grant)
    else $error("run granted with run source 0 to 3");
  AST_LOCK: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    (lock == `RTSS_LOCK_NO_REV) |=> !dir_reverse)
    else $error("reverse produced while reverse is locked");
  AST_EQUAL_OFF: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    (win_bus[2].start_min == win_bus[2].stop_min) |-> !win_act[2])
    else $error("window with equal start and stop is active");
endmodule : rtss_sched
`default_nettype wire

/* tb/rtss_drive_model.sv */
// behavioural drive command logic on the far side of the schedule block
// assumes the schedule outputs are registered on pclk
`timescale 1ns/1ps
`default_nettype none
module rtss_drive_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run_grant,
  input wire logic freq_from_sched,
  input wire logic [1:0] speed_stage,
  output logic running_q,
  output logic [1:0] stage_q
);
  logic running_d;
  logic [1:0] stage_d;

  // ------------------------------------------------
  // drive state
  // ------------------------------------------------
  // keypad stage 0 unless the schedule owns the frequency
  always_comb begin
    running_d = run_grant;
    stage_d = freq_from_sched ? speed_stage : 2'h0;
  end

  // one cycle of command latency, like a real drive input latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_q <= 1'b0;
      stage_q <= 2'h0;
    end else begin
      running_q <= running_d;
      stage_q <= stage_d;
    end
  end
endmodule : rtss_drive_model
`default_nettype wire

/* tb/rtss_sched_tb.sv */
// directed testbench for the schedule block, apb tasks and output checks
// assumes a zero-wait apb slave and outputs settled 4 edges after inputs
`timescale 1ns/1ps
`default_nettype none
module rtss_sched_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0] now_day = 3'h1;
  logic [4:0] now_hour = 5'h00;
  logic [5:0] now_minute = 6'h00;
  logic timer_di = 1'b0;
  logic offset_di = 1'b0;
  logic fire_mode_cfg = 1'b0;
  logic kinetic_ride_through_en = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, dir_reverse, run_grant, freq_from_sched, dir_from_sched;
  logic [3:0] timer_state, relay_out;
  logic [1:0] speed_stage, drv_stage;
  logic drv_running;
  int mismatches = 0;
  int tests_run = 0;

  always #2 pclk = ~pclk;

  rtss_sched rtss_sched_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .now_day(now_day), .now_hour(now_hour),
    .now_minute(now_minute), .timer_di(timer_di), .offset_di(offset_di),
    .fire_mode_cfg(fire_mode_cfg), .kinetic_ride_through_en(kinetic_ride_through_en),
    .timer_state(timer_state), .speed_stage(speed_stage), .dir_reverse(dir_reverse),
    .run_grant(run_grant), .freq_from_sched(freq_from_sched),
    .dir_from_sched(dir_from_sched), .relay_out(relay_out));
  rtss_drive_model rtss_drive_model_i (.pclk(pclk), .presetn(presetn),
    .run_grant(run_grant), .freq_from_sched(freq_from_sched), .speed_stage(speed_stage),
    .running_q(drv_running), .stage_q(drv_stage));

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one apb transfer; waits an edge first so no signal is driven twice per step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
  endtask : apb

  task automatic settle;
    repeat (4) @(posedge pclk);
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
    settle();
  endtask : wr

  task automatic at(input logic [2:0] d, input logic [4:0] h, input logic [5:0] m);
    @(posedge pclk);
    now_day <= d;
    now_hour <= h;
    now_minute <= m;
    settle();
  endtask : at

  function automatic logic [31:0] win(input logic [10:0] s, input logic [10:0] e,
    input logic [2:0] sd, input logic [2:0] ed);
    return {4'h0, ed, sd, e, s};
  endfunction : win

  // mode word: tfun, offset sel, speed sel, dir bits, run src, freq src, lock
  function automatic logic [31:0] mode(input logic [1:0] tf, input logic [1:0] os,
    input logic [2:0] sp, input logic [3:0] dr, input logic [2:0] rs, input logic [3:0] fs,
    input logic [1:0] lk);
    return {10'h000, lk, fs, 1'b0, rs, dr, 1'b0, sp, os, tf};
  endfunction : mode

  function automatic logic [31:0] outs();
    return {22'h0, timer_state, speed_stage, dir_reverse, run_grant, freq_from_sched,
      dir_from_sched};
  endfunction : outs

  // f packs dir_reverse, run_grant, freq_from_sched, dir_from_sched
  function automatic logic [31:0] o(input logic [3:0] ts, input logic [1:0] st,
    input logic [3:0] f);
    return {22'h0, ts, st, f};
  endfunction : o

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check("reset outputs", outs(), 32'h0000_0000);
    apb(8'h00, 1'b0, 32'h0000_0000);
    check("mode reset", rd, 32'h0000_0000);
    apb(8'h24, 1'b0, 32'h0000_0000);
    check("unmapped error", {31'h0, er}, 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    apb(8'h20, 1'b1, 32'hffff_ffff);
    check("status write error", {31'h0, er}, 32'h0000_0001);
    // windows: w1 mon 08:00-12:00, w2 mon 10:00-11:40, w3 start==stop, w4 tue
    wr(8'h08, win(11'h1e0, 11'h2d0, 3'h1, 3'h1));
    wr(8'h0c, win(11'h258, 11'h2bc, 3'h1, 3'h1));
    wr(8'h10, win(11'h258, 11'h258, 3'h1, 3'h7));
    wr(8'h14, win(11'h1e0, 11'h2d0, 3'h2, 3'h2));
    wr(8'h18, 32'h0000_0258);
    wr(8'h04, 32'h1004_0201);
    wr(8'h1c, 32'h0000_0011);
    wr(8'h00, mode(2'h1, 2'h0, 3'h5, 4'h2, 3'h4, 4'h6, 2'h0));
    at(3'h1, 5'h09, 6'h00);
    check("t1 only", outs(), o(4'h1, 2'h1, 4'hf));
    check("drive runs", {31'h0, drv_running}, 32'h0000_0001);
    at(3'h1, 5'h0b, 6'h00);
    check("t1 and t2", outs(), o(4'h3, 2'h3, 4'h7));
    check("relay", {28'h0, relay_out}, 32'h0000_0001);
    check("drive stage", {30'h0, drv_stage}, 32'h0000_0003);
    apb(8'h20, 1'b0, 32'h0000_0000);
    check("status", rd, 32'h0000_05b3);
    at(3'h1, 5'h0c, 6'h00);
    check("stop minute", outs(), o(4'h1, 2'h1, 4'hf));
    at(3'h1, 5'h0c, 6'h01);
    check("after stop", outs(), o(4'h0, 2'h0, 4'h0));
    at(3'h2, 5'h0b, 6'h00);
    check("other weekday", outs(), o(4'h0, 2'h0, 4'h0));
    at(3'h1, 5'h0b, 6'h00);
    wr(8'h00, mode(2'h1, 2'h1, 3'h5, 4'h2, 3'h4, 4'h6, 2'h0));
    check("offset on", outs(), o(4'hb, 2'h3, 4'h7));
    wr(8'h00, mode(2'h1, 2'h2, 3'h5, 4'h2, 3'h4, 4'h6, 2'h0));
    check("offset di low", {28'h0, timer_state}, 32'h0000_0003);
    @(posedge pclk);
    offset_di <= 1'b1;
    settle();
    check("offset di high", {28'h0, timer_state}, 32'h0000_000b);
    wr(8'h04, 32'h100f_0201);
    wr(8'h00, mode(2'h1, 2'h0, 3'h5, 4'h2, 3'h4, 4'h6, 2'h0));
    check("mask 15", outs(), o(4'h7, 2'h3, 4'h7));
    for (int s = 1; s <= 4; s++) begin
      wr(8'h00, mode(2'h1, 2'h0, s[2:0], 4'h2, 3'h4, 4'h6, 2'h0));
      check("single timer", {29'h0, run_grant, speed_stage}, {29'h0, s < 4, 2'h0});
    end
    for (int r = 0; r < 4; r++) begin
      wr(8'h00, mode(2'h1, 2'h0, 3'h5, 4'h2, r[2:0], 4'h6, 2'h0));
      check("run source", {31'h0, run_grant}, 32'h0000_0000);
    end
    wr(8'h00, mode(2'h1, 2'h0, 3'h0, 4'h2, 3'h4, 4'h6, 2'h0));
    check("speed off", {30'h0, freq_from_sched, dir_from_sched}, 32'h0000_0000);
    wr(8'h00, mode(2'h1, 2'h0, 3'h5, 4'h2, 3'h4, 4'h0, 2'h0));
    check("freq source", {30'h0, run_grant, freq_from_sched}, 32'h0000_0002);
    check("drive keypad stage", {30'h0, drv_stage}, 32'h0000_0000);
    at(3'h1, 5'h09, 6'h00);
    wr(8'h00, mode(2'h1, 2'h0, 3'h5, 4'h2, 3'h4, 4'h6, 2'h1));
    check("reverse locked", {30'h0, dir_reverse, run_grant}, 32'h0000_0000);
    wr(8'h00, mode(2'h1, 2'h0, 3'h5, 4'h2, 3'h4, 4'h6, 2'h2));
    check("reverse allowed", {30'h0, dir_reverse, run_grant}, 32'h0000_0003);
    wr(8'h00, mode(2'h2, 2'h0, 3'h5, 4'h2, 3'h4, 4'h6, 2'h0));
    check("timer di low", {28'h0, timer_state}, 32'h0000_0000);
    @(posedge pclk);
    timer_di <= 1'b1;
    settle();
    check("timer di high", {28'h0, timer_state}, 32'h0000_0005);
    wr(8'h00, mode(2'h0, 2'h0, 3'h5, 4'h2, 3'h4, 4'h6, 2'h0));
    check("timers off", {28'h0, timer_state}, 32'h0000_0000);
    wr(8'h00, mode(2'h1, 2'h0, 3'h5, 4'h2, 3'h4, 4'h6, 2'h0));
    @(posedge pclk);
    fire_mode_cfg <= 1'b1;
    settle();
    check("fire mode", {30'h0, run_grant, freq_from_sched}, 32'h0000_0000);
    @(posedge pclk);
    fire_mode_cfg <= 1'b0;
    kinetic_ride_through_en <= 1'b1;
    settle();
    check("ride through", {30'h0, run_grant, freq_from_sched}, 32'h0000_0000);
    end_of_test();
  end
endmodule : rtss_sched_tb
`default_nettype wire
